// ===== design/ddspc_pkg.sv
// Summary of operation
// - 32-bit accumulator adds step while gate on and FIFO not full, wraps.
// - Step word unsigned; above half counts downward.
// - Zero step holds present phase.
// - Clear-phase bit forces accumulator to zero.
// - Reset: active clear set, pending copy cleared.
// - Keep upper 19 phase bits only.
// - Each phase gives 14-bit cosine sample.
// - Crystal pin picks oscillator or external reference.
// - Power-down stops clock in crystal mode; oscillator and buffer run.
// - Buffer bit enables crystal-out buffer in crystal mode.
// - Multiplier 4 to 20 multiplies reference.
// - Other multiplier values bypass, loop off.
// - Multiplier independent of charge-pump bits.
// - Crystal-out shows buffered oscillator when enabled.
// - Profile pin change commits pending buffer.
package ddspc_pkg;

  localparam int ACC_W = 32;
  localparam int PHASE_W = 19;
  localparam int AMP_W = 14;
  localparam int MULT_W = 5;
  localparam int FIFO_DEPTH = 4;

  localparam logic [ACC_W-1:0] STEP_RESET = 32'h0000_0000;
  localparam logic CLEAR_ACTIVE_RESET = 1'b1;
  localparam logic CLEAR_PENDING_RESET = 1'b0;
  localparam logic [MULT_W-1:0] MULT_MIN = 5'h04;
  localparam logic [MULT_W-1:0] MULT_MAX = 5'h14;
  localparam logic [AMP_W-1:0] AMP_MID = 14'h2000;

  localparam int CLK_PERIOD_NS = 8;
  localparam int SWITCH_GAP_NS = 64;
  localparam int SWITCH_GAP_CYC = (SWITCH_GAP_NS + CLK_PERIOD_NS - 1)
                                  / CLK_PERIOD_NS;

  // Quarter-wave cosine, 33 points, full scale 8191
  localparam logic [12:0] COS_TAB [0:32] = '{
    13'h1FFF, 13'h1FF5, 13'h1FD8, 13'h1FA6, 13'h1F62, 13'h1F0A,
    13'h1E9E, 13'h1E20, 13'h1D90, 13'h1CED, 13'h1C38, 13'h1B72,
    13'h1A9B, 13'h19B3, 13'h18BC, 13'h17B5, 13'h16A0, 13'h157D,
    13'h144C, 13'h130F, 13'h11C7, 13'h1073, 13'h0F15, 13'h0DAE,
    13'h0C3F, 13'h0AC7, 13'h094A, 13'h07C6, 13'h063E, 13'h04B2,
    13'h0323, 13'h0192, 13'h0000
  };

  typedef enum logic [2:0] {
    CS_RUN  = 3'b001,
    CS_GATE = 3'b010,
    CS_HOLD = 3'b100
  } ddspc_clk_state_e;

  typedef struct packed {
    logic oscOn;
    logic xtalOutOn;
    logic clkRun;
    logic pllOn;
    logic refFromOsc;
    logic [MULT_W-1:0] pllMult;
  } ddspc_clk_cfg_s;

  localparam ddspc_clk_cfg_s CLK_CFG_RESET = '{
    oscOn: 1'b0, xtalOutOn: 1'b0, clkRun: 1'b1,
    pllOn: 1'b0, refFromOsc: 1'b0, pllMult: 5'h00
  };

endpackage

// ===== design/ddspc_core.sv
`timescale 1ns/1ns
`default_nettype none

module ddspc_fifo #(
  parameter int WIDTH = 14,
  parameter int DEPTH = 4
) (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Fill side
  input wire logic inValid,
  input wire logic [WIDTH-1:0] inData,
  output logic inReady,
  // Drain side
  output logic outValid,
  output logic [WIDTH-1:0] outData,
  input wire logic outReady
);
  localparam int AW = $clog2(DEPTH);

  logic [WIDTH-1:0] mem_ff [0:DEPTH-1];
  logic [WIDTH-1:0] nxt_mem [0:DEPTH-1];
  logic [AW-1:0] wrPtr_ff, nxt_wrPtr;
  logic [AW-1:0] rdPtr_ff, nxt_rdPtr;
  logic [AW:0] count_ff, nxt_count;
  logic push, pop;

  assign push = inValid && inReady;
  assign pop = outValid && outReady;
  assign inReady = (count_ff != DEPTH[AW:0]);
  assign outValid = (count_ff != '0);
  assign outData = mem_ff[rdPtr_ff];

  always_comb begin
    nxt_mem = mem_ff;
    nxt_wrPtr = wrPtr_ff;
    nxt_rdPtr = rdPtr_ff;
    nxt_count = count_ff;
    if (push) begin
      nxt_mem[wrPtr_ff] = inData;
      nxt_wrPtr = (wrPtr_ff == AW'(DEPTH - 1)) ? '0 : wrPtr_ff + 1'b1;
    end
    if (pop) begin
      nxt_rdPtr = (rdPtr_ff == AW'(DEPTH - 1)) ? '0 : rdPtr_ff + 1'b1;
    end
    if (push && !pop) begin
      nxt_count = count_ff + 1'b1;
    end else if (pop && !push) begin
      nxt_count = count_ff - 1'b1;
    end
  end

  always_ff @(posedge mclk) begin
    mem_ff <= nxt_mem;
    if (!rst_b) begin
      wrPtr_ff <= '0;
      rdPtr_ff <= '0;
      count_ff <= '0;
    end else begin
      wrPtr_ff <= nxt_wrPtr;
      rdPtr_ff <= nxt_rdPtr;
      count_ff <= nxt_count;
    end
  end
endmodule

module ddspc_core
  import ddspc_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Pending control buffer
  input wire logic [ACC_W-1:0] pendTuningStepWord,
  input wire logic pendClearPhase,
  input wire logic commitPulse,
  input wire logic [1:0] profileSelectPins,
  // Clock source controls
  input wire logic crystalModePin,
  input wire logic clkInPowerDown,
  input wire logic oscBufferEnable,
  input wire logic [MULT_W-1:0] refMultiplier,
  input wire logic [1:0] chargePumpCtl,
  // Sample stream to the DAC
  output logic sampleValid,
  output logic [AMP_W-1:0] sampleData,
  input wire logic sampleReady,
  // Status
  output logic activeClearPhase,
  output logic [ACC_W-1:0] accumulatorPhaseOut,
  // Clock generator controls
  output ddspc_clk_cfg_s clkCfg,
  output logic coreClkGate
);

  // Interpolated quarter-wave cosine, offset binary out
  function automatic logic [AMP_W-1:0] cosLookup(
    input logic [PHASE_W-1:0] ph
  );
    logic [17:0] inQuad;
    logic [5:0] idx;
    logic [5:0] hiIdx;
    logic [11:0] frac;
    logic [12:0] lo;
    logic [12:0] hi;
    logic [24:0] prod;
    logic [12:0] mag;
    // Exact mirror so quarter points land on table ends
    inQuad = ph[PHASE_W-2] ? (18'h2_0000 - {1'b0, ph[16:0]})
                           : {1'b0, ph[16:0]};
    idx = inQuad[17:12];
    hiIdx = (idx == 6'd32) ? 6'd32 : idx + 6'd1;
    frac = inQuad[11:0];
    lo = COS_TAB[idx];
    hi = COS_TAB[hiIdx];
    prod = (lo - hi) * frac;
    mag = lo - prod[24:12];
    if (ph[PHASE_W-1] ^ ph[PHASE_W-2]) begin
      cosLookup = AMP_MID - {1'b0, mag};
    end else begin
      cosLookup = AMP_MID + {1'b0, mag};
    end
  endfunction

  // Pins enter through two flops first
  logic [1:0] psMeta_ff, psSync_ff, psPrev_ff;
  logic modeMeta_ff, modeSync_ff;

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      psMeta_ff <= 2'h0;
      psSync_ff <= 2'h0;
      psPrev_ff <= 2'h0;
      modeMeta_ff <= 1'b0;
      modeSync_ff <= 1'b0;
    end else begin
      psMeta_ff <= profileSelectPins;
      psSync_ff <= psMeta_ff;
      psPrev_ff <= psSync_ff;
      modeMeta_ff <= crystalModePin;
      modeSync_ff <= modeMeta_ff;
    end
  end

  // Commit of pending buffer into active controls
  logic commit;
  logic [ACC_W-1:0] step_ff, nxt_step;
  logic clear_ff, nxt_clear;

  assign commit = commitPulse || (psSync_ff != psPrev_ff);

  always_comb begin
    nxt_step = step_ff;
    nxt_clear = clear_ff;
    if (commit) begin
      nxt_step = pendTuningStepWord;
      nxt_clear = pendClearPhase;
    end
  end

  // Pending copy lives outside; it must reset to zero
  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      step_ff <= STEP_RESET;
      clear_ff <= CLEAR_ACTIVE_RESET;
    end else begin
      step_ff <= nxt_step;
      clear_ff <= nxt_clear;
    end
  end

  // Clock source sequencer
  ddspc_clk_state_e clkState_ff, nxt_clkState;
  ddspc_clk_cfg_s applied_ff, nxt_applied;
  ddspc_clk_cfg_s target;
  logic [7:0] gapCnt_ff, nxt_gapCnt;
  logic gate_ff, nxt_gate;
  logic multInRange;

  assign multInRange = (refMultiplier >= MULT_MIN)
                       && (refMultiplier <= MULT_MAX);

  always_comb begin
    target.oscOn = modeSync_ff;
    target.refFromOsc = modeSync_ff;
    target.xtalOutOn = modeSync_ff && oscBufferEnable;
    target.clkRun = !(modeSync_ff && clkInPowerDown);
    // Charge-pump bits do not enter here
    target.pllOn = multInRange;
    target.pllMult = multInRange ? refMultiplier : 5'h00;
  end

  // Gate first, switch while stopped, then release
  always_comb begin
    nxt_clkState = clkState_ff;
    nxt_applied = applied_ff;
    nxt_gapCnt = gapCnt_ff;
    nxt_gate = gate_ff;
    case (clkState_ff)
      CS_RUN: begin
        nxt_gate = applied_ff.clkRun;
        if (target != applied_ff) begin
          nxt_gate = 1'b0;
          nxt_gapCnt = 8'h00;
          nxt_clkState = CS_GATE;
        end
      end
      CS_GATE: begin
        nxt_gapCnt = gapCnt_ff + 8'h01;
        if (gapCnt_ff == 8'(SWITCH_GAP_CYC - 1)) begin
          nxt_applied = target;
          nxt_gapCnt = 8'h00;
          nxt_clkState = CS_HOLD;
        end
      end
      CS_HOLD: begin
        nxt_gapCnt = gapCnt_ff + 8'h01;
        if (gapCnt_ff == 8'(SWITCH_GAP_CYC - 1)) begin
          nxt_gate = applied_ff.clkRun;
          nxt_clkState = CS_RUN;
        end
      end
      default: begin
        nxt_gate = 1'b0;
        nxt_clkState = CS_RUN;
      end
    endcase
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      clkState_ff <= CS_RUN;
      applied_ff <= CLK_CFG_RESET;
      gapCnt_ff <= 8'h00;
      gate_ff <= 1'b1;
    end else begin
      clkState_ff <= nxt_clkState;
      applied_ff <= nxt_applied;
      gapCnt_ff <= nxt_gapCnt;
      gate_ff <= nxt_gate;
    end
  end

  // Phase accumulator; stalls while the clock is gated or FIFO full
  logic [ACC_W-1:0] acc_ff, nxt_acc;
  logic fifoInReady;
  logic advance;
  logic [PHASE_W-1:0] truncPhase;
  logic [AMP_W-1:0] amp;

  assign advance = gate_ff && fifoInReady;
  assign truncPhase = acc_ff[ACC_W-1 -: PHASE_W];
  assign amp = cosLookup(truncPhase);

  always_comb begin
    nxt_acc = acc_ff;
    if (clear_ff) begin
      nxt_acc = '0;
    end else if (advance) begin
      // Unsigned add; large steps wrap, i.e. count down
      nxt_acc = acc_ff + step_ff;
    end
  end

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      acc_ff <= '0;
    end else begin
      acc_ff <= nxt_acc;
    end
  end

  // One sample per advanced phase
  logic fifoOutValid;
  logic [AMP_W-1:0] fifoOutData;
  logic outValid_ff, nxt_outValid;
  logic [AMP_W-1:0] outData_ff, nxt_outData;
  logic fifoPop;

  ddspc_fifo #(
    .WIDTH(AMP_W),
    .DEPTH(FIFO_DEPTH)
  ) u_fifo (
    .mclk(mclk),
    .rst_b(rst_b),
    .inValid(gate_ff),
    .inData(amp),
    .inReady(fifoInReady),
    .outValid(fifoOutValid),
    .outData(fifoOutData),
    .outReady(fifoPop)
  );

  // Output skid register keeps the DAC port flop-driven
  assign fifoPop = !outValid_ff || sampleReady;

  always_comb begin
    nxt_outValid = outValid_ff;
    nxt_outData = outData_ff;
    if (fifoPop) begin
      nxt_outValid = fifoOutValid;
      if (fifoOutValid) begin
        nxt_outData = fifoOutData;
      end
    end
  end

  // Status and clock controls registered for clean outputs
  logic [ACC_W-1:0] phaseOut_ff;
  logic clearOut_ff;

  always_ff @(posedge mclk) begin
    if (!rst_b) begin
      outValid_ff <= 1'b0;
      outData_ff <= AMP_MID;
      phaseOut_ff <= '0;
      clearOut_ff <= CLEAR_ACTIVE_RESET;
    end else begin
      outValid_ff <= nxt_outValid;
      outData_ff <= nxt_outData;
      phaseOut_ff <= acc_ff;
      clearOut_ff <= clear_ff;
    end
  end

  assign sampleValid = outValid_ff;
  assign sampleData = outData_ff;
  assign accumulatorPhaseOut = phaseOut_ff;
  assign activeClearPhase = clearOut_ff;
  assign clkCfg = applied_ff;
  assign coreClkGate = gate_ff;

endmodule

`default_nettype wire

// ===== testbench/ddspc_sva.sv
`timescale 1ns/1ns
`default_nettype none
module ddspc_sva
  import ddspc_pkg::*;
(
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Observed outputs and sampleReady input
  input wire logic sampleValid,
  input wire logic [AMP_W-1:0] sampleData,
  input wire logic sampleReady,
  input wire logic activeClearPhase,
  input wire logic [ACC_W-1:0] accumulatorPhaseOut,
  input wire ddspc_clk_cfg_s clkCfg,
  input wire logic coreClkGate
);
  default clocking cb @(posedge mclk); endclocking
  default disable iff (!rst_b);
  property p_clr;
    activeClearPhase && $past(activeClearPhase) |-> accumulatorPhaseOut == 0;
  endproperty
  a_clr: assert property (p_clr) else $error("phase not cleared");
  property p_osc;
    clkCfg.oscOn == clkCfg.refFromOsc;
  endproperty
  a_osc: assert property (p_osc) else $error("source mismatch");
  property p_xtal;
    clkCfg.xtalOutOn |-> clkCfg.oscOn;
  endproperty
  a_xtal: assert property (p_xtal) else $error("buffer without osc");
  property p_stop;
    !clkCfg.clkRun |-> clkCfg.oscOn && !coreClkGate;
  endproperty
  a_stop: assert property (p_stop) else $error("clock not stopped");
  property p_mult;
    clkCfg.pllOn |-> clkCfg.pllMult inside {[4:20]};
  endproperty
  a_mult: assert property (p_mult) else $error("bad multiplier");
  property p_byp;
    !clkCfg.pllOn |-> clkCfg.pllMult == 5'h00;
  endproperty
  a_byp: assert property (p_byp) else $error("bypass mult");
  property p_sw;
    $changed(clkCfg) |-> !coreClkGate && $past(coreClkGate, 8) == 1'b0;
  endproperty
  a_sw: assert property (p_sw) else $error("switch while clocked");
  property p_gap;
    $fell(coreClkGate) |=> !coreClkGate [*8];
  endproperty
  a_gap: assert property (p_gap) else $error("short gate gap");
  property p_hold;
    sampleValid && !sampleReady |=> sampleValid && $stable(sampleData);
  endproperty
  a_hold: assert property (p_hold) else $error("sample dropped");
endmodule
`default_nettype wire

// ===== testbench/ddspc_dac_model.sv
`timescale 1ns/1ns
`default_nettype none
module ddspc_dac_model (
  // Clock and reset
  input wire logic mclk,
  input wire logic rst_b,
  // Sample stream
  input wire logic sampleValid,
  input wire logic [13:0] sampleData,
  output logic sampleReady,
  // Stall request
  input wire logic dacStall
);
  logic [13:0] got[$];
  always @(posedge mclk) begin
    if (rst_b && sampleValid && sampleReady)
      got.push_back(sampleData);
    sampleReady <= rst_b && !dacStall;
  end
endmodule
`default_nettype wire

// ===== testbench/ddspc_core_bench.sv
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin compares++; if ((g) !== (e)) begin \
  n_mismatch++; $display("Error %s exp %h got %h", nm, e, g); end end
module ddspc_core_bench import ddspc_pkg::*; ;
  logic mclk = 0, rst_b = 0, commitPulse = 0, pendClearPhase = 0;
  logic crystalModePin = 0, clkInPowerDown = 0, oscBufferEnable = 0;
  logic stallOn = 0, dacStall = 0, sampleReady, sampleValid;
  logic activeClearPhase, coreClkGate;
  logic [31:0] pendTuningStepWord = 0, accumulatorPhaseOut, p, s;
  logic [1:0] profileSelectPins = 0, chargePumpCtl = 0;
  logic [4:0] refMultiplier = 0, x;
  logic [13:0] sampleData;
  logic [4:0] mults [0:5] = '{5'h03, 5'h04, 5'h14, 5'h15, 5'h09, 5'h00};
  ddspc_clk_cfg_s clkCfg, ec;
  int n_mismatch = 0, compares = 0, cycles = 0, j, k;
  ddspc_core ddspc_core_inst (.mclk, .rst_b, .pendTuningStepWord,
    .pendClearPhase, .commitPulse, .profileSelectPins, .crystalModePin,
    .clkInPowerDown, .oscBufferEnable, .refMultiplier, .chargePumpCtl,
    .sampleValid, .sampleData, .sampleReady, .activeClearPhase,
    .accumulatorPhaseOut, .clkCfg, .coreClkGate);
  ddspc_dac_model ddspc_dac_model_inst (.mclk, .rst_b, .sampleValid,
    .sampleData, .sampleReady, .dacStall);
  initial forever #4 mclk = ~mclk;
  task results;
    $display("mismatches %0d compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0)
      $display("All checks passed");
    else
      $display("Checks failed");
    $finish;
  endtask
  always @(posedge mclk) begin
    cycles++;
    dacStall <= stallOn && $urandom_range(1);
    // Run needs about 870 cycles
    if (cycles == 6000) begin
      n_mismatch++;
      results();
    end
  end
  task tick(input int n);
    repeat (n) @(posedge mclk);
  endtask
  task look(input int n);
    repeat (n) @(posedge mclk);
    #1;
  endtask
  task commit(input logic [31:0] w, input logic c);
    @(posedge mclk);
    pendTuningStepWord <= w;
    pendClearPhase <= c;
    commitPulse <= 1'b1;
    @(posedge mclk);
    commitPulse <= 1'b0;
  endtask
  function logic [13:0] amp(input logic [31:0] ph);
    case (ph[31:30])
      2'h0: return 14'h3fff;
      2'h2: return 14'h0001;
      default: return 14'h2000;
    endcase
  endfunction
  function ddspc_clk_cfg_s cfgOf(input logic m, d, b, input logic [4:0] v);
    logic on;
    on = v inside {[4:20]};
    return '{oscOn: m, xtalOutOn: m & b, clkRun: !(m & d), pllOn: on,
      refFromOsc: m, pllMult: on ? v : 5'h00};
  endfunction
  initial begin
    void'($urandom(32'hc7c6));
    tick(4);
    rst_b <= 1'b1;
    look(10);
    `CHK("clear", 1'b1, activeClearPhase)
    `CHK("acc", 32'h0000_0000, accumulatorPhaseOut)
    tick(1);
    profileSelectPins <= 2'h1;
    look(10);
    `CHK("clear", 1'b0, activeClearPhase)
    for (j = 0; j < 4; j++) begin
      s = (j == 0) ? 32'hffff_ffff : $urandom;
      commit(s, 1'b0);
      look(6);
      p = accumulatorPhaseOut;
      look(1);
      `CHK("step", p + s, accumulatorPhaseOut)
    end
    commit(32'h0000_0000, 1'b0);
    look(4);
    p = accumulatorPhaseOut;
    look(5);
    `CHK("hold", p, accumulatorPhaseOut)
    for (j = 1; j < 4; j++) begin
      s = {j[1:0], 30'h0000_0000};
      commit(s, 1'b1);
      stallOn <= 1'b1;
      look(8);
      `CHK("zero", 32'h0000_0000, accumulatorPhaseOut)
      ddspc_dac_model_inst.got.delete();
      commit(s, 1'b0);
      tick(90);
      k = 1;
      while (ddspc_dac_model_inst.got[k] === 14'h3fff)
        k++;
      for (int i = 0; i < 12; i++)
        `CHK("amp", amp(s * i), ddspc_dac_model_inst.got[k - 1 + i])
    end
    stallOn <= 1'b0;
    // Multipliers at both limits and just outside them, plus bypass
    for (j = 0; j < 6; j++) begin
      tick(1);
      x = mults[j];
      crystalModePin <= (j != 2);
      clkInPowerDown <= (j == 3);
      oscBufferEnable <= j[0];
      chargePumpCtl <= 2'($urandom);
      refMultiplier <= x;
      // Settle time stands in for the lock wait
      look(80);
      ec = cfgOf(j != 2, j == 3, j[0], x);
      `CHK("cfg", ec, clkCfg)
      `CHK("gate", ec.clkRun, coreClkGate)
    end
    results();
  end
endmodule
bind ddspc_core ddspc_sva ddspc_sva_inst (.mclk, .rst_b, .sampleValid,
  .sampleData, .sampleReady, .activeClearPhase, .accumulatorPhaseOut,
  .clkCfg, .coreClkGate);
`default_nettype wire
